// file: hw/lmc_mode_output.sv
// Chosen here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
`include "lmc_cfg.svh"
module lmc_mode_output import lmc_pkg::*; #(
	parameter int WD_PERIOD_CYC = `LMC_WD_PERIOD_US * `LMC_CLK_MHZ,
	parameter int WD_FIRST_CYC = `LMC_WD_FIRST_US * `LMC_CLK_MHZ
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic clk_en_in,
	input wire logic [3:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	output logic irq_out,
	input wire logic wd_kick_in,
	input wire logic wake_event_in,
	input wire logic reg_undervoltage_in,
	input wire logic battery_undervoltage_in,
	input wire logic switch_control_input_in,
	input wire logic lin_bus_in,
	input wire logic txd_in,
	output logic system_reset_output_n_out,
	output logic wake_request_output_out,
	output logic supply_enable_output_out,
	output logic fallback_output_out,
	output logic high_side_switch_out,
	output logic regulator_on_out,
	output logic rxd_out,
	output logic rxd_oe_out,
	output logic lin_tx_en_out,
	output logic lin_txd_out,
	output logic slope_ctrl_off_out
);
	function automatic logic is_active(input lmc_mode_t m);
		is_active = (m == mode_standby) || (m == mode_normal) || (m == mode_fast);
	endfunction : is_active

	function automatic logic regulator_on(input lmc_mode_t m, input lmc_fault_t f);
		if (m == mode_sleep) begin
			regulator_on = 1'b0;
		end else if (m == mode_failsafe) begin
			regulator_on = !((f == fault_thermal) || (f == fault_reg_ov) ||
				(f == fault_reg_short));
		end else begin
			regulator_on = 1'b1;
		end
	endfunction : regulator_on

	lmc_mode_t mode_reg, mode_next;
	lmc_fault_t fault_reg, fault_next;
	logic ack_reg, ack_next, bus_req, wr_do;
	logic [31:0] rdata_next;
	logic [2:0] status_reg, status_next, mask_reg, mask_next;
	logic [31:0] wd_cnt_reg, wd_cnt_next, wd_limit_reg, wd_limit_next;
	logic wd_fail, enter_tx, reg_on;
	logic tx_blk_reg, tx_blk_next, wake_seen_reg, wake_seen_next;
	logic wait_next, irq_next, rst_n_next, wake_req_next, supply_next;
	logic fallback_next, hss_next, rxd_next, rxd_oe_next;
	logic tx_en_next, txd_next, slope_next;

	assign bus_req = avs_read_in || avs_write_in;
	// Write lands only on the edge where waitrequest is seen low
	assign wr_do = avs_write_in && ack_reg && avs_byteenable_in[0];

	always_comb begin
		ack_next = bus_req && !ack_reg;
		wait_next = !ack_next;
		rdata_next = avs_readdata_out;
		if (bus_req && !ack_reg) begin
			if (avs_address_in == `LMC_ADDR_CTRL) begin
				rdata_next = {26'h0, fault_reg, mode_reg};
			end else if (avs_address_in == `LMC_ADDR_STATUS) begin
				rdata_next = {29'h0, status_reg};
			end else if (avs_address_in == `LMC_ADDR_MASK) begin
				rdata_next = {29'h0, mask_reg};
			end else if (avs_address_in == `LMC_ADDR_STATE) begin
				rdata_next = {24'h0, tx_blk_reg, wake_seen_reg, lin_tx_en_out,
					fallback_output_out, regulator_on_out, mode_reg};
			end else begin
				rdata_next = 32'h0;
			end
		end

		// Mode only moves on a host write, so standby holds after a wake
		mode_next = mode_reg;
		fault_next = fault_reg;
		mask_next = mask_reg;
		if (wr_do && avs_address_in == `LMC_ADDR_CTRL) begin
			// Undefined mode codes are dropped, keeping the state legal
			if (avs_writedata_in[`LMC_CTRL_MODE_LSB +: 3] <= `LMC_MODE_MAX) begin
				mode_next = lmc_mode_t'(avs_writedata_in[`LMC_CTRL_MODE_LSB +: 3]);
			end
			fault_next = lmc_fault_t'(avs_writedata_in[`LMC_CTRL_FAULT_LSB +: 3]);
		end
		if (wr_do && avs_address_in == `LMC_ADDR_MASK) begin
			mask_next = avs_writedata_in[2:0];
		end

		wd_fail = 1'b0;
		wd_cnt_next = wd_cnt_reg + 32'h1;
		wd_limit_next = wd_limit_reg;
		if (mode_next != mode_reg) begin
			wd_cnt_next = 32'h0;
			wd_limit_next = (mode_next == mode_standby) ? 32'(WD_FIRST_CYC) :
				32'(WD_PERIOD_CYC);
		end else if (!is_active(mode_reg)) begin
			wd_cnt_next = 32'h0;
		end else if (wd_kick_in) begin
			wd_cnt_next = 32'h0;
			wd_limit_next = 32'(WD_PERIOD_CYC);
		end else if (wd_cnt_reg >= wd_limit_reg - 32'h1) begin
			wd_fail = 1'b1;
			wd_cnt_next = 32'h0;
			wd_limit_next = 32'(WD_PERIOD_CYC);
		end

		enter_tx = (mode_next != mode_reg) &&
			((mode_next == mode_normal) || (mode_next == mode_fast));
		tx_blk_next = tx_blk_reg;
		if (enter_tx) begin
			tx_blk_next = !txd_in;
		end else if (txd_in) begin
			tx_blk_next = 1'b0;
		end

		wake_seen_next = wake_seen_reg;
		if (wake_event_in) begin
			wake_seen_next = 1'b1;
		end else if (mode_reg == mode_standby && mode_next != mode_standby) begin
			wake_seen_next = 1'b0;
		end

		// Set beats a same-cycle clear so no event is lost
		status_next = status_reg;
		if (wr_do && avs_address_in == `LMC_ADDR_STATUS) begin
			status_next = status_reg & ~avs_writedata_in[2:0];
		end
		status_next[`LMC_ST_WD_BIT] = status_next[`LMC_ST_WD_BIT] | wd_fail;
		status_next[`LMC_ST_WAKE_BIT] = status_next[`LMC_ST_WAKE_BIT] | wake_event_in;
		status_next[`LMC_ST_TXBLK_BIT] = status_next[`LMC_ST_TXBLK_BIT] |
			(enter_tx && !txd_in);
		irq_next = |(status_next & mask_next);

		fallback_next = fallback_output_out;
		if (mode_next == mode_failsafe) begin
			fallback_next = 1'b1;
		end else if (mode_next == mode_sleep) begin
			fallback_next = 1'b0;
		end else if (mode_reg == mode_failsafe && fault_reg != fault_supervision) begin
			fallback_next = 1'b0;
		end else if (wd_fail && mode_reg != mode_fast) begin
			fallback_next = 1'b1;
		end

		reg_on = regulator_on(mode_next, fault_next);
		rst_n_next = reg_on && mode_next != mode_restart && !reg_undervoltage_in;
		wake_req_next = reg_on && mode_next != mode_sleep && !battery_undervoltage_in;
		supply_next = mode_next != mode_sleep && !battery_undervoltage_in;
		hss_next = is_active(mode_next) && switch_control_input_in;

		rxd_oe_next = 1'b1;
		case (mode_next)
			mode_sleep: begin
				rxd_next = 1'b0;
				rxd_oe_next = 1'b0;
			end
			mode_standby: begin
				rxd_next = !wake_seen_next;
			end
			mode_normal, mode_fast: begin
				rxd_next = lin_bus_in;
			end
			default: begin
				rxd_next = 1'b1;
			end
		endcase

		tx_en_next = ((mode_next == mode_normal) || (mode_next == mode_fast)) &&
			!tx_blk_next;
		// Idle the line recessive whenever the driver is off
		txd_next = tx_en_next ? txd_in : 1'b1;
		slope_next = mode_next == mode_fast;
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			mode_reg <= mode_restart;
			fault_reg <= fault_none;
			ack_reg <= 1'b0;
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out <= 32'h0;
			status_reg <= `LMC_STATUS_RST;
			mask_reg <= `LMC_MASK_RST;
			wd_cnt_reg <= 32'h0;
			wd_limit_reg <= 32'h0;
			tx_blk_reg <= 1'b0;
			wake_seen_reg <= 1'b1;
			irq_out <= 1'b0;
			system_reset_output_n_out <= 1'b0;
			wake_request_output_out <= 1'b0;
			supply_enable_output_out <= 1'b0;
			fallback_output_out <= 1'b0;
			high_side_switch_out <= 1'b0;
			regulator_on_out <= 1'b0;
			rxd_out <= 1'b1;
			rxd_oe_out <= 1'b1;
			lin_tx_en_out <= 1'b0;
			lin_txd_out <= 1'b1;
			slope_ctrl_off_out <= 1'b0;
		end else if (clk_en_in) begin
			mode_reg <= mode_next;
			fault_reg <= fault_next;
			ack_reg <= ack_next;
			avs_waitrequest_out <= wait_next;
			avs_readdata_out <= rdata_next;
			status_reg <= status_next;
			mask_reg <= mask_next;
			wd_cnt_reg <= wd_cnt_next;
			wd_limit_reg <= wd_limit_next;
			tx_blk_reg <= tx_blk_next;
			wake_seen_reg <= wake_seen_next;
			irq_out <= irq_next;
			system_reset_output_n_out <= rst_n_next;
			wake_request_output_out <= wake_req_next;
			supply_enable_output_out <= supply_next;
			fallback_output_out <= fallback_next;
			high_side_switch_out <= hss_next;
			regulator_on_out <= reg_on;
			rxd_out <= rxd_next;
			rxd_oe_out <= rxd_oe_next;
			lin_tx_en_out <= tx_en_next;
			lin_txd_out <= txd_next;
			slope_ctrl_off_out <= slope_next;
		end
	end

	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);

	a_wd_off_modes: assert property (!is_active(mode_reg) |-> !wd_fail)
		else $error("supervision failure in a mode with the timer off");
	a_wd_first_long: assert property (clk_en_in && mode_next == mode_standby &&
		mode_reg != mode_standby |=> wd_limit_reg == 32'(WD_FIRST_CYC))
		else $error("standby entry without long first window");
	a_fast_flag_only: assert property (clk_en_in && wd_fail && mode_reg == mode_fast &&
		mode_next == mode_fast |=> status_reg[`LMC_ST_WD_BIT] &&
		$stable(fallback_output_out) && mode_reg == mode_fast)
		else $error("fast mode timer failure did more than flag");
	a_reset_low_off: assert property (clk_en_in && (!regulator_on(mode_next, fault_next) ||
		reg_undervoltage_in) |=> !system_reset_output_n_out)
		else $error("reset output high with regulator off or low");
	a_fault_reg_off: assert property (clk_en_in && mode_next == mode_failsafe &&
		fault_next == fault_thermal |=> !regulator_on_out)
		else $error("regulator left on after thermal fault");
	a_fault_reg_on: assert property (clk_en_in && mode_next == mode_failsafe &&
		fault_next == fault_reg_uv |=> regulator_on_out)
		else $error("regulator off after undervoltage fault");
	a_tx_hold_dom: assert property (clk_en_in && enter_tx && !txd_in
		|=> !lin_tx_en_out && tx_blk_reg)
		else $error("transmitter enabled on dominant entry");
	a_wake_needs_reg: assert property (!regulator_on_out |-> !wake_request_output_out)
		else $error("wake request high with regulator off");
	a_standby_hold: assert property (clk_en_in && mode_reg == mode_standby &&
		!(wr_do && avs_address_in == `LMC_ADDR_CTRL) |=> mode_reg == mode_standby)
		else $error("standby left without host write");
	a_hss_off: assert property (clk_en_in && !is_active(mode_next)
		|=> !high_side_switch_out)
		else $error("high-side switch on in an off mode");
	a_fallback_fs: assert property (clk_en_in && mode_next == mode_failsafe
		|=> fallback_output_out ##0 $past(mode_next) == mode_failsafe)
		else $error("fallback not asserted in fail-safe");
	a_rxd_sleep: assert property (clk_en_in && mode_next == mode_sleep |=> !rxd_oe_out)
		else $error("receive output driven in sleep");
	a_tx_off_modes: assert property (clk_en_in && mode_next != mode_normal &&
		mode_next != mode_fast |=> !lin_tx_en_out && lin_txd_out)
		else $error("transmitter on outside normal and fast");
	a_fast_slope: assert property (clk_en_in && mode_next == mode_fast && !tx_blk_next
		|=> lin_tx_en_out && slope_ctrl_off_out)
		else $error("fast mode transmit not enabled slope-free");
	a_mode_legal: assert property (clk_en_in |=> mode_reg <= `LMC_MODE_MAX &&
		slope_ctrl_off_out == (mode_reg == mode_fast) &&
		(!high_side_switch_out || is_active(mode_reg)))
		else $error("outputs disagree with the mode variable");
endmodule : lmc_mode_output
`default_nettype wire

// file: include/lmc_cfg.svh
`ifndef LMC_CFG_SVH
`define LMC_CFG_SVH
`define LMC_ADDR_CTRL 4'h0
`define LMC_ADDR_STATUS 4'h4
`define LMC_ADDR_MASK 4'h8
`define LMC_ADDR_STATE 4'hc
`define LMC_CTRL_MODE_LSB 0
`define LMC_CTRL_FAULT_LSB 3
`define LMC_ST_WD_BIT 0
`define LMC_ST_WAKE_BIT 1
`define LMC_ST_TXBLK_BIT 2
`define LMC_MODE_MAX 3'h5
`define LMC_STATUS_RST 3'h0
`define LMC_MASK_RST 3'h0
`define LMC_CLK_MHZ 100
`define LMC_WD_PERIOD_US 100
`define LMC_WD_FIRST_US 400
`endif

// file: include/lmc_pkg.sv
package lmc_pkg;
	typedef enum logic [2:0] {
		mode_restart,
		mode_sleep,
		mode_standby,
		mode_normal,
		mode_failsafe,
		mode_fast
	} lmc_mode_t;
	typedef enum logic [2:0] {
		fault_none,
		fault_supervision,
		fault_reg_uv,
		fault_restart_cnt,
		fault_sleep_wait,
		fault_thermal,
		fault_reg_ov,
		fault_reg_short
	} lmc_fault_t;
endpackage : lmc_pkg

// file: dv/lmc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module lmc_host_model (
	input wire logic hold_dom_in,
	input wire logic node_dom_in,
	input wire logic tx_en_in,
	input wire logic lin_txd_in,
	output logic txd_out,
	output logic lin_bus_out
);
	// Host may pin TXD dominant across a mode entry
	assign txd_out = ~hold_dom_in;
	// Pulled-up bus, any dominant driver wins
	assign lin_bus_out = ~node_dom_in & ~(tx_en_in & ~lin_txd_in);
endmodule : lmc_host_model
`default_nettype wire

// file: dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "lmc_cfg.svh"
module tb_top import lmc_pkg::*;;
	logic clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic [3:0] avs_address_in = 4'h0;
	logic avs_read_in = 1'b0;
	logic avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h0;
	logic wd_kick_in = 1'b0;
	logic wake_event_in = 1'b0;
	logic reg_undervoltage_in = 1'b0;
	logic switch_control_input_in = 1'b1;
	logic host_dom = 1'b0;
	logic node_dom = 1'b0;
	logic bat_uv = 1'b0;
	logic clk_en = 1'b1;
	logic [3:0] be = 4'h1;
	wire logic rxd_oe;
	logic [31:0] d;
	logic [31:0] avs_readdata_out;
	logic avs_waitrequest_out, irq_out, system_reset_output_n_out, wake_request_output_out;
	logic supply_enable_output_out, fallback_output_out, high_side_switch_out;
	logic regulator_on_out, rxd_out, lin_tx_en_out, lin_txd_out, slope_ctrl_off_out;
	wire logic lin_bus_in;
	wire logic txd_in;
	int err_count = 0;
	int compares = 0;
	int cyc = 0;

	always #5 clk_in = ~clk_in;

	// Short windows keep the timer scenarios brief
	lmc_mode_output #(.WD_PERIOD_CYC(8), .WD_FIRST_CYC(20)) i_lmc_mode_output (
		.clk_in, .reset_n_in, .clk_en_in(clk_en), .avs_address_in, .avs_read_in,
		.avs_write_in, .avs_writedata_in, .avs_byteenable_in(be), .avs_readdata_out,
		.avs_waitrequest_out, .irq_out, .wd_kick_in, .wake_event_in, .reg_undervoltage_in,
		.battery_undervoltage_in(bat_uv), .switch_control_input_in, .lin_bus_in, .txd_in,
		.system_reset_output_n_out, .wake_request_output_out, .supply_enable_output_out,
		.fallback_output_out, .high_side_switch_out, .regulator_on_out, .rxd_out,
		.rxd_oe_out(rxd_oe), .lin_tx_en_out, .lin_txd_out, .slope_ctrl_off_out
	);

	lmc_host_model i_lmc_host_model (
		.hold_dom_in(host_dom), .node_dom_in(node_dom), .tx_en_in(lin_tx_en_out),
		.lin_txd_in(lin_txd_out), .txd_out(txd_in), .lin_bus_out(lin_bus_in)
	);

	task automatic wrap_up;
		$display("Checks %0d, errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up

	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count++;
			wrap_up();
		end
	end

	task automatic chk(input string n, input logic e, input logic g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("FAIL %s expected %b seen %b", n, e, g);
		end
	endtask : chk

	task automatic cy(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : cy

	// Request held until waitrequest is seen low at an edge
	task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] v);
		@(posedge clk_in);
		avs_address_in <= a;
		avs_writedata_in <= v;
		avs_write_in <= w;
		avs_read_in <= ~w;
		do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
		d = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
	endtask : acc

	task automatic md(input lmc_mode_t m, input lmc_fault_t f);
		acc(1'b1, `LMC_ADDR_CTRL, {26'h0, f, m});
		cy(3);
	endtask : md

	initial begin
		repeat (10) @(posedge clk_in);
		reset_n_in <= 1'b1;
		cy(3);
		chk("rst_n", 1'b0, system_reset_output_n_out);
		chk("hss", 1'b0, high_side_switch_out);
		chk("rxd", 1'b1, rxd_out);
		chk("tx_en", 1'b0, lin_tx_en_out);
		cy(30);
		acc(1'b0, `LMC_ADDR_STATUS, 32'h0);
		chk("wd_fail", 1'b0, d[`LMC_ST_WD_BIT]);
		md(mode_sleep, fault_none);
		chk("rst_n", 1'b0, system_reset_output_n_out);
		chk("wake_request_output", 1'b0, wake_request_output_out);
		chk("rxd_oe", 1'b0, rxd_oe);
		chk("fallback", 1'b0, fallback_output_out);
		chk("hss", 1'b0, high_side_switch_out);
		md(mode_standby, fault_none);
		chk("rxd", 1'b0, rxd_out);
		chk("rst_n", 1'b1, system_reset_output_n_out);
		chk("hss", 1'b1, high_side_switch_out);
		@(posedge clk_in) switch_control_input_in <= 1'b0;
		cy(4);
		chk("hss", 1'b0, high_side_switch_out);
		acc(1'b0, `LMC_ADDR_STATUS, 32'h0);
		chk("wd_fail", 1'b0, d[`LMC_ST_WD_BIT]);
		cy(15);
		chk("fallback", 1'b1, fallback_output_out);
		@(posedge clk_in) host_dom <= 1'b1;
		wd_kick_in <= 1'b1;
		md(mode_normal, fault_supervision);
		chk("tx_en", 1'b0, lin_tx_en_out);
		chk("fallback", 1'b1, fallback_output_out);
		@(posedge clk_in) host_dom <= 1'b0;
		cy(3);
		chk("tx_en", 1'b1, lin_tx_en_out);
		chk("slope_off", 1'b0, slope_ctrl_off_out);
		@(posedge clk_in) node_dom <= 1'b1;
		cy(3);
		chk("rxd", 1'b0, rxd_out);
		for (int f = 1; f < 8; f++) begin
			md(mode_failsafe, lmc_fault_t'(f));
			chk("reg_on", f < 5, regulator_on_out);
			chk("wake_request_output", f < 5, wake_request_output_out);
			chk("supply", 1'b1, supply_enable_output_out);
			if (f > 4)
				chk("rst_n", 1'b0, system_reset_output_n_out);
			chk("fallback", 1'b1, fallback_output_out);
			chk("hss", 1'b0, high_side_switch_out);
			chk("tx_en", 1'b0, lin_tx_en_out);
		end
		md(mode_standby, fault_thermal);
		chk("fallback", 1'b0, fallback_output_out);
		chk("rxd", 1'b1, rxd_out);
		@(posedge clk_in) wake_event_in <= 1'b1;
		@(posedge clk_in) wake_event_in <= 1'b0;
		cy(3);
		chk("rxd", 1'b0, rxd_out);
		chk("reg_on", 1'b1, regulator_on_out);
		acc(1'b0, `LMC_ADDR_STATE, 32'h0);
		chk("mode", 1'b1, d[2:0] === mode_standby);
		@(posedge clk_in) wd_kick_in <= 1'b0;
		md(mode_normal, fault_none);
		cy(15);
		chk("fallback", 1'b1, fallback_output_out);
		md(mode_failsafe, fault_thermal);
		md(mode_fast, fault_thermal);
		chk("fallback", 1'b0, fallback_output_out);
		chk("slope_off", 1'b1, slope_ctrl_off_out);
		chk("tx_en", 1'b1, lin_tx_en_out);
		// Clear the sticky timer flag so only fast-mode failures can set it
		acc(1'b1, `LMC_ADDR_STATUS, 32'h1);
		cy(25);
		acc(1'b0, `LMC_ADDR_STATE, 32'h0);
		chk("mode", 1'b1, d[2:0] === mode_fast);
		chk("fallback", 1'b0, fallback_output_out);
		acc(1'b0, `LMC_ADDR_STATUS, 32'h0);
		chk("wd_fail", 1'b1, d[`LMC_ST_WD_BIT]);
		@(posedge clk_in) be <= 4'h0;
		acc(1'b1, `LMC_ADDR_MASK, 32'h1);
		cy(3);
		chk("irq_be0", 1'b0, irq_out);
		@(posedge clk_in) be <= 4'h1;
		acc(1'b1, `LMC_ADDR_MASK, 32'h1);
		cy(3);
		chk("irq", 1'b1, irq_out);
		acc(1'b1, `LMC_ADDR_MASK, 32'h0);
		cy(3);
		chk("irq", 1'b0, irq_out);
		@(posedge clk_in) reg_undervoltage_in <= 1'b1;
		cy(3);
		chk("rst_n", 1'b0, system_reset_output_n_out);
		@(posedge clk_in) reg_undervoltage_in <= 1'b0;
		cy(3);
		chk("rst_n", 1'b1, system_reset_output_n_out);
		@(posedge clk_in) bat_uv <= 1'b1;
		cy(3);
		chk("wake_request_output", 1'b0, wake_request_output_out);
		chk("supply", 1'b0, supply_enable_output_out);
		@(posedge clk_in) bat_uv <= 1'b0;
		clk_en <= 1'b0;
		switch_control_input_in <= 1'b1;
		cy(4);
		chk("hss_frozen", 1'b0, high_side_switch_out);
		@(posedge clk_in) clk_en <= 1'b1;
		cy(3);
		chk("hss", 1'b1, high_side_switch_out);
		chk("wake_request_output", 1'b1, wake_request_output_out);
		md(mode_sleep, fault_none);
		acc(1'b1, `LMC_ADDR_MASK, 32'h7);
		acc(1'b1, `LMC_ADDR_STATUS, 32'h7);
		cy(12);
		acc(1'b0, `LMC_ADDR_STATUS, 32'h0);
		chk("status", 1'b1, d[2:0] === 3'h0);
		chk("irq", 1'b0, irq_out);
		acc(1'b0, 4'h2, 32'h0);
		chk("unmapped", 1'b1, d === 32'h0);
		acc(1'b1, `LMC_ADDR_CTRL, 32'h6);
		acc(1'b0, `LMC_ADDR_STATE, 32'h0);
		chk("mode_code6", 1'b1, d[2:0] === mode_sleep);
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
